// *** include/adc_ctrl_pkg.sv ***
// shared map, field layout and types of the converter control block
package adc_ctrl_pkg;

  // bus and datapath widths
  localparam int ADDR_W  = 10;
  localparam int DATA_W  = 32;
  localparam int REG_W   = 8;
  localparam int RES_W   = 10;
  localparam int CHAN_W  = 2;
  localparam int IRQ_W   = 2;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL    = 8'hE1;
  localparam logic [7:0] IDX_RESULT_HI  = 8'hE2;
  localparam logic [7:0] IDX_PERIPH_IE  = 8'hE8;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hD0;
  localparam logic [7:0] IDX_IRQ_CLEAR  = 8'hD1;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hD2;

  // turns a register index into its word-aligned byte address
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction

  localparam logic [ADDR_W-1:0] ADDR_CONTROL    = byte_addr(IDX_CONTROL);
  localparam logic [ADDR_W-1:0] ADDR_RESULT_HI  = byte_addr(IDX_RESULT_HI);
  localparam logic [ADDR_W-1:0] ADDR_PERIPH_IE  = byte_addr(IDX_PERIPH_IE);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = byte_addr(IDX_IRQ_STATUS);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR  = byte_addr(IDX_IRQ_CLEAR);
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = byte_addr(IDX_IRQ_ENABLE);

  // control/status register fields
  localparam int CTL_RES1_BIT   = 7;
  localparam int CTL_RES0_BIT   = 6;
  localparam int CTL_EXT_EN_BIT = 5;
  localparam int CTL_DONE_BIT   = 4;
  localparam int CTL_START_BIT  = 3;
  localparam int CTL_CLKSEL_BIT = 2;
  localparam int CTL_CHAN_HI    = 1;
  localparam int CTL_CHAN_LO    = 0;

  // result split: high register holds bits 9..2, control holds 1..0
  localparam int RES_HI_MSB = 9;
  localparam int RES_HI_LSB = 2;

  // peripheral interrupt enable fields, bits 7..6 reserved
  localparam int PIE_BRAKE_BIT = 5;
  localparam int PIE_WDOG_BIT  = 4;
  localparam int PIE_CMPB_BIT  = 3;
  localparam int PIE_CMPA_BIT  = 2;
  localparam int PIE_KEYP_BIT  = 1;
  localparam int PIE_TWI_BIT   = 0;
  localparam logic [REG_W-1:0] PIE_MASK = 8'h3F;

  // interrupt status layout
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_REJECT_BIT = 1;

  // reset values
  localparam logic [REG_W-1:0]  REG_RST  = 8'h00;
  localparam logic [RES_W-1:0]  RES_RST  = 10'h000;
  localparam logic [CHAN_W-1:0] CHAN_RST = 2'h0;
  localparam logic [IRQ_W-1:0]  IRQ_RST  = 2'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

  // conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY,
    ST_FINISH
  } conv_state_t;

endpackage

// *** rtl/adc_conv_ctrl.sv ***
// Design decision made here: the APB register port.
`timescale 1ns/10ps
// Function
// - software writing one to start bit while idle begins a conversion
// - start bit reads one while converting, cleared right after done flag sets
// - writing zero to the start bit does nothing; only hardware clears it
// - while start bit is one, every software or pin start is ignored
// - while done flag is one, no new conversion begins
// - only hardware sets done flag; software writes one ignored, zero clears
// - done and start both zero means idle and ready to accept a start
// - done one, start zero means complete; next start needs done cleared
// - done and start may both read one briefly; a transient state
// - channel select writable only while done and start are both zero
// - channel code 0..3 routes analog input 0..3 to the converter
// - high result register shows result bits 9..2 in bits 7..0
module adc_conv_ctrl (
  // clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
  input  wire logic [adc_ctrl_pkg::DATA_W-1:0] pwdata,
  output logic      [adc_ctrl_pkg::DATA_W-1:0] prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // analog converter core
  output logic                                 conv_start,
  output logic      [adc_ctrl_pkg::CHAN_W-1:0] conv_channel,
  output logic                                 conv_clock_select,
  input  wire logic [adc_ctrl_pkg::RES_W-1:0]  conv_result,
  input  wire logic                            conv_valid,
  // external trigger pin
  input  wire logic                            external_start_pin,
  // peripheral interrupt enables for the interrupt controller
  output logic      [adc_ctrl_pkg::REG_W-1:0]  periph_irq_enable,
  // interrupt
  output logic                                 irq
);
  import adc_ctrl_pkg::*;

  // zero-extends a register image onto the bus; upper bus bits always read zero
  function automatic logic [DATA_W-1:0] reg_word(input logic [REG_W-1:0] img);
    return {{(DATA_W-REG_W){1'b0}}, img};
  endfunction

  // the interrupt registers are narrower still; pad them to a register first
  function automatic logic [REG_W-1:0] irq_image(input logic [IRQ_W-1:0] flags);
    return {{(REG_W-IRQ_W){1'b0}}, flags};
  endfunction

  conv_state_t        state_r;
  conv_state_t        state_nxt;
  logic               done_r;
  logic               done_nxt;
  logic               ext_en_r;
  logic               ext_en_nxt;
  logic               clksel_r;
  logic               clksel_nxt;
  logic [CHAN_W-1:0]  chan_r;
  logic [CHAN_W-1:0]  chan_nxt;
  logic [RES_W-1:0]   result_r;
  logic [RES_W-1:0]   result_nxt;
  logic [REG_W-1:0]   pie_r;
  logic [REG_W-1:0]   pie_nxt;
  logic [IRQ_W-1:0]   irq_stat_r;
  logic [IRQ_W-1:0]   irq_stat_nxt;
  logic [IRQ_W-1:0]   irq_en_r;
  logic [IRQ_W-1:0]   irq_en_nxt;
  logic               start_nxt;
  logic               irq_nxt;

  // bus handshake signals
  wire                access;
  wire                first_access;
  wire                commit;
  wire                rd_capture;
  wire                pready_nxt;
  wire                pslverr_nxt;
  wire [DATA_W-1:0]   prdata_nxt;

  // address decode
  wire                hit_control;
  wire                hit_result_hi;
  wire                hit_periph_ie;
  wire                hit_irq_status;
  wire                hit_irq_clear;
  wire                hit_irq_enable;
  wire                addr_hit;

  // write strobes
  wire                wr_control;
  wire                wr_periph_ie;
  wire                wr_irq_clear;
  wire                wr_irq_enable;

  // conversion control terms
  wire                ext_rise;
  wire                start_bit;
  wire                idle_ready;
  wire                sw_start_req;
  wire                pin_start_req;
  wire                start_req;
  wire                start_accept;
  wire                conv_finish;
  wire                sw_done_clear;
  wire                chan_open;
  wire [IRQ_W-1:0]    irq_events;
  wire [IRQ_W-1:0]    irq_clear_mask;

  // register images for reads
  wire [REG_W-1:0]    control_image;
  wire [REG_W-1:0]    result_hi_image;
  wire [REG_W-1:0]    irq_stat_image;
  wire [REG_W-1:0]    irq_en_image;

  // external pin edge detector
  // the pin may arrive at any time; only levels that two stages agree on count
  start_pin_sync u_start_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (external_start_pin),
    .rise    (ext_rise)
  );

  // apb: one wait cycle, so the answer always comes two cycles after setup;
  // read data are fetched in that wait cycle, which keeps the mux off the output path
  assign access       = psel & penable;
  assign first_access = access & ~pready;
  assign commit       = access & pready;
  assign rd_capture   = first_access & ~pwrite;
  assign pready_nxt   = first_access;
  assign pslverr_nxt  = first_access & ~addr_hit;

  // decode is shared between read mux, error and write strobes
  // full-address compare: an alias of a register is unmapped and answers an error
  assign hit_control    = (paddr == ADDR_CONTROL);
  assign hit_result_hi  = (paddr == ADDR_RESULT_HI);
  assign hit_periph_ie  = (paddr == ADDR_PERIPH_IE);
  assign hit_irq_status = (paddr == ADDR_IRQ_STATUS);
  assign hit_irq_clear  = (paddr == ADDR_IRQ_CLEAR);
  assign hit_irq_enable = (paddr == ADDR_IRQ_ENABLE);
  assign addr_hit       = hit_control | hit_result_hi | hit_periph_ie
                        | hit_irq_status | hit_irq_clear | hit_irq_enable;

  // writes take effect only at the edge that completes the access
  // a read never has side effects, so polling the control register is safe
  assign wr_control    = commit & pwrite & hit_control;
  assign wr_periph_ie  = commit & pwrite & hit_periph_ie;
  assign wr_irq_clear  = commit & pwrite & hit_irq_clear;
  assign wr_irq_enable = commit & pwrite & hit_irq_enable;

  // start bit is busy or the short finish step, never a stored software value
  assign start_bit = (state_r != ST_IDLE);
  // idle only with both flags low; done high blocks like busy does
  assign idle_ready = (state_r == ST_IDLE) & ~done_r;
  // writing zero to the start bit is no request at all
  assign sw_start_req  = wr_control & pwdata[CTL_START_BIT];
  assign pin_start_req = ext_en_r & ext_rise;
  assign start_req     = sw_start_req | pin_start_req;
  // requests while busy or done are dropped, not queued
  // queuing would let a stale trigger start a conversion long after the fact
  assign start_accept  = start_req & idle_ready;
  assign conv_finish   = (state_r == ST_BUSY) & conv_valid;

  // done is judged before the write, so a clear-and-start write does not start
  assign sw_done_clear = wr_control & ~pwdata[CTL_DONE_BIT];
  assign chan_open     = idle_ready;

  // sticky events: completion and a start that was refused
  // logging the refusal lets software tell that a trigger was lost
  assign irq_events[IRQ_DONE_BIT]   = conv_finish;
  assign irq_events[IRQ_REJECT_BIT] = start_req & ~idle_ready;
  assign irq_clear_mask = wr_irq_clear ? pwdata[IRQ_W-1:0] : IRQ_RST;

  // control image: result low bits on top, status flags in the middle
  assign control_image = {result_r[RES_HI_LSB-1:0],
                          ext_en_r,
                          done_r,
                          start_bit,
                          clksel_r,
                          chan_r};
  assign result_hi_image = result_r[RES_HI_MSB:RES_HI_LSB];

  // interrupt registers share the narrow layout of bits 1..0
  assign irq_stat_image = irq_image(irq_stat_r);
  assign irq_en_image   = irq_image(irq_en_r);

  // read mux; narrow registers sit in the low bits, the rest read zero
  assign prdata_nxt =
      ~rd_capture    ? prdata                    :
      hit_control    ? reg_word(control_image)   :
      hit_result_hi  ? reg_word(result_hi_image) :
      hit_periph_ie  ? reg_word(pie_r)           :
      hit_irq_status ? reg_word(irq_stat_image)  :
      hit_irq_enable ? reg_word(irq_en_image)    :
      DATA_RST;

  // sequencer: idle, converting, then one cycle where done and start both show
  // the finish step is harmless to software, and done is already set by then,
  // so no start can slip in between the end of busy and the done block
  always_comb begin
    state_nxt = state_r;
    start_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (start_accept) begin
          state_nxt = ST_BUSY;
          start_nxt = 1'b1;
        end
      end
      ST_BUSY: begin
        if (conv_valid) begin
          state_nxt = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // done flag: hardware set wins over a software clear in the same cycle
  // losing that race the other way would hide a fresh result from software
  always_comb begin
    done_nxt = done_r;
    if (sw_done_clear) begin
      done_nxt = 1'b0;
    end
    if (conv_finish) begin
      done_nxt = 1'b1;
    end
  end

  // configuration fields; channel held while busy or done
  // clock select and trigger enable may change at any time; only the channel
  // is frozen, since the core must convert the input that was asked for
  always_comb begin
    ext_en_nxt = ext_en_r;
    clksel_nxt = clksel_r;
    chan_nxt   = chan_r;
    pie_nxt    = pie_r;
    irq_en_nxt = irq_en_r;
    if (wr_control) begin
      ext_en_nxt = pwdata[CTL_EXT_EN_BIT];
      clksel_nxt = pwdata[CTL_CLKSEL_BIT];
      if (chan_open) begin
        chan_nxt = pwdata[CTL_CHAN_HI:CTL_CHAN_LO];
      end
    end
    if (wr_periph_ie) begin
      pie_nxt = pwdata[REG_W-1:0] & PIE_MASK;
    end
    if (wr_irq_enable) begin
      irq_en_nxt = pwdata[IRQ_W-1:0];
    end
  end

  // result capture and interrupt status; set wins over write-one-to-clear
  // the result only moves on completion, so a read while busy shows the last one
  assign result_nxt   = conv_finish ? conv_result : result_r;
  assign irq_stat_nxt = irq_events | (irq_stat_r & ~irq_clear_mask);
  assign irq_nxt      = |(irq_stat_nxt & irq_en_nxt);

  // sequencer and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= ST_IDLE;
      done_r     <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      done_r     <= done_nxt;
      conv_start <= start_nxt;
    end
  end

  // configuration and result storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_en_r <= 1'b0;
      clksel_r <= 1'b0;
      chan_r   <= CHAN_RST;
      result_r <= RES_RST;
      pie_r    <= REG_RST;
    end else begin
      ext_en_r <= ext_en_nxt;
      clksel_r <= clksel_nxt;
      chan_r   <= chan_nxt;
      result_r <= result_nxt;
      pie_r    <= pie_nxt;
    end
  end

  // outputs to the converter core and the interrupt controller mirror the held configuration
  // loaded from the next values so the core sees a write with the register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_channel      <= CHAN_RST;
      conv_clock_select <= 1'b0;
      periph_irq_enable <= REG_RST;
    end else begin
      conv_channel      <= chan_nxt;
      conv_clock_select <= clksel_nxt;
      periph_irq_enable <= pie_nxt;
    end
  end

  // interrupt status, mask and line
  // the line is built from next values so it never lags the status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= IRQ_RST;
      irq_en_r   <= IRQ_RST;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_en_r   <= irq_en_nxt;
      irq        <= irq_nxt;
    end
  end

  // bus answer registers
  // read data hold between reads; a master takes them in the pready cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= DATA_RST;
    end else begin
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
      prdata  <= prdata_nxt;
    end
  end

endmodule // adc_conv_ctrl

// *** rtl/start_pin_sync.sv ***
`timescale 1ns/10ps
// brings the external start pin into pclk and reports its rising edges
module start_pin_sync (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // asynchronous pin
  input  wire logic pin_in,
  // one-cycle pulse on a filtered rising edge
  output logic      rise
);

  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic level_r;
  logic level_nxt;
  logic rise_nxt;

  // the level only moves once the last two stages agree, so one odd sample is no edge
  assign level_nxt = (sync2_r == sync3_r) ? sync3_r : level_r;
  assign rise_nxt  = level_nxt & ~level_r;

  // three-stage chain; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      level_r <= 1'b0;
      rise    <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      level_r <= level_nxt;
      rise    <= rise_nxt;
    end
  end

endmodule // start_pin_sync

// *** testbench/adc_conv_ctrl_sva.sv ***
`timescale 1ns/10ps
// port watcher; keeps a shadow of busy, done and result to judge the outputs
module adc_conv_ctrl_sva (
  // clock and reset
  input wire logic                            pclk,
  input wire logic                            presetn,
  // register bus
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0] pwdata,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0] prdata,
  input wire logic                            pready,
  // converter core and interrupt
  input wire logic                            conv_start,
  input wire logic [adc_ctrl_pkg::CHAN_W-1:0] conv_channel,
  input wire logic                            conv_clock_select,
  input wire logic [adc_ctrl_pkg::RES_W-1:0]  conv_result,
  input wire logic                            conv_valid,
  input wire logic                            irq
);
  import adc_ctrl_pkg::*;
  logic             busy_r, done_r, ien_r;
  logic [RES_W-1:0] res_r;
  // commit decode; done is judged before the write lands
  wire commit = psel && penable && pready;
  wire ctl_wr = commit && pwrite && paddr == ADDR_CONTROL;
  wire ctl_rd = commit && !pwrite && paddr == ADDR_CONTROL;
  wire fin    = conv_valid && busy_r;
  // shadow state; a done set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      ien_r  <= 1'b0;
      res_r  <= RES_RST;
    end else begin
      busy_r <= conv_start || (busy_r && !conv_valid);
      done_r <= fin || (done_r && !(ctl_wr && !pwdata[CTL_DONE_BIT]));
      if (fin)
        res_r <= conv_result;
      if (commit && pwrite && paddr == ADDR_IRQ_ENABLE)
        ien_r <= pwdata[IRQ_DONE_BIT];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  a_one_wait: assert property (s_setup ##1 penable |-> s_answer)
    else $error("bus answer not after one wait state");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_busy_blocks: assert property (busy_r |-> !conv_start)
    else $error("start while busy");
  a_done_blocks: assert property (done_r |-> !conv_start)
    else $error("start while done set");
  a_write_starts: assert property (ctl_wr && pwdata[CTL_START_BIT] && !busy_r && !done_r
    && !conv_start |=> conv_start) else $error("idle start request dropped");
  a_chan_locked: assert property ($changed(conv_channel) |->
    $past(ctl_wr && !busy_r && !done_r && !conv_start)
    && conv_channel == $past(pwdata[CTL_CHAN_HI:CTL_CHAN_LO])) else $error("channel moved");
  a_clksel_follow: assert property ($changed(conv_clock_select) |-> $past(ctl_wr)
    && conv_clock_select == $past(pwdata[CTL_CLKSEL_BIT])) else $error("clock select moved");
  a_irq_done: assert property (fin && ien_r |-> ##2 irq)
    else $error("no interrupt after conversion");
  a_result_hi: assert property (commit && !pwrite && paddr == ADDR_RESULT_HI |->
    prdata == {24'h000000, $past(res_r[RES_HI_MSB:RES_HI_LSB])}) else $error("bad result");
  a_ctl_read: assert property (ctl_rd |-> prdata[CTL_RES1_BIT:CTL_RES0_BIT] ==
    $past(res_r[1:0]) && prdata[CTL_DONE_BIT] == $past(done_r)) else $error("bad control");
endmodule // adc_conv_ctrl_sva

bind adc_conv_ctrl adc_conv_ctrl_sva i_adc_conv_ctrl_sva (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .conv_start, .conv_channel, .conv_clock_select,
  .conv_result, .conv_valid, .irq);

// *** testbench/conv_core_model.sv ***
`timescale 1ns/10ps
// converter core stand-in: answers a start after a short or a long delay
module conv_core_model (
  // clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // from the block
  input  wire logic                            conv_start,
  input  wire logic [adc_ctrl_pkg::CHAN_W-1:0] conv_channel,
  input  wire logic                            slow,
  // to the block
  output logic      [adc_ctrl_pkg::RES_W-1:0]  conv_result,
  output logic                                 conv_valid
);
  import adc_ctrl_pkg::*;
  int                cnt_r;
  logic [CHAN_W-1:0] chan_r;
  // long delay leaves software time to poke a busy block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r       <= 0;
      chan_r      <= CHAN_RST;
      conv_valid  <= 1'b0;
      conv_result <= RES_RST;
    end else begin
      conv_valid  <= 1'b0;
      conv_result <= ~conv_result; // no stale value outside the valid cycle
      if (conv_start) begin
        cnt_r  <= slow ? 40 : 3;
        chan_r <= conv_channel;
      end else if (cnt_r == 1) begin
        cnt_r       <= 0;
        conv_valid  <= 1'b1;
        conv_result <= {chan_r, 6'h2D, ~chan_r};
      end else if (cnt_r > 1) begin
        cnt_r <= cnt_r - 1;
      end
    end
  end
endmodule // conv_core_model

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
// drives the converter control block over its bus and its start pin
module tb_top;
  import adc_ctrl_pkg::*;
  logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, err;
  logic              pwrite = 1'b0, external_start_pin = 1'b0, slow = 1'b0;
  logic [ADDR_W-1:0] paddr = 10'h000;
  logic [DATA_W-1:0] pwdata = 32'h0, prdata, rd;
  logic [RES_W-1:0]  conv_result;
  logic [CHAN_W-1:0] conv_channel;
  logic [REG_W-1:0]  periph_irq_enable;
  logic              pready, pslverr, conv_start, conv_valid, conv_clock_select, irq;
  int                fail_count = 0, n_tests = 0;
  always #25 pclk = ~pclk;
  adc_conv_ctrl i_adc_conv_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .conv_start, .conv_channel, .conv_clock_select, .conv_result,
    .conv_valid, .external_start_pin, .periph_irq_enable, .irq);
  conv_core_model i_conv_core_model (.pclk, .presetn, .conv_start, .conv_channel, .slow,
    .conv_result, .conv_valid);
  task automatic print_verdict;
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one bus transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      chk(32'h0, 32'h1);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // window long enough for pin filtering plus acceptance
  task automatic wait_start(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (30) begin
      @(posedge pclk);
      if (conv_start === 1'b1)
        seen = 1'b1;
    end
    chk(32'(seen), 32'(exp));
  endtask
  task automatic wait_done;
    int n;
    for (n = 0; n < 12; n++) begin
      apb(1'b0, ADDR_CONTROL, 32'h0);
      if (rd[CTL_DONE_BIT] === 1'b1)
        break;
    end
    if (n == 12) begin
      chk(32'h0, 32'h1);
      print_verdict();
    end
  endtask
  function automatic logic [DATA_W-1:0] res_hi(input logic [1:0] ch);
    return {24'h0, ch, 6'h2D};
  endfunction
  task automatic t_regs;
    rdchk(ADDR_CONTROL, 32'h0);
    wr(ADDR_RESULT_HI, 32'hFF);
    rdchk(ADDR_RESULT_HI, 32'h0);
    wr(ADDR_PERIPH_IE, 32'hFFFF_FFFF);
    rdchk(ADDR_PERIPH_IE, {24'h0, PIE_MASK});
    chk(32'(periph_irq_enable), {24'h0, PIE_MASK});
    rdchk(ADDR_IRQ_CLEAR, 32'h0);
    apb(1'b0, 10'h3FC, 32'h0);
    chk(32'(err), 32'h1);
    wr(ADDR_CONTROL, 32'h17);
    rdchk(ADDR_CONTROL, 32'h07);
    chk(32'(conv_clock_select), 32'h1);
    chk(32'(conv_channel), 32'h3);
  endtask
  // long conversion poked while busy, then refused while done
  task automatic t_sw_conv;
    slow <= 1'b1;
    wr(ADDR_IRQ_ENABLE, 32'h1);
    wr(ADDR_CONTROL, 32'h0A);
    rdchk(ADDR_CONTROL, 32'h0A);
    wr(ADDR_CONTROL, 32'h05);
    rdchk(ADDR_CONTROL, 32'h0E);
    wr(ADDR_CONTROL, 32'h0E);
    wait_done();
    rdchk(ADDR_CONTROL, 32'h56);
    rdchk(ADDR_RESULT_HI, res_hi(2'h2));
    rdchk(ADDR_IRQ_STATUS, 32'h3);
    chk(32'(irq), 32'h1);
    wr(ADDR_CONTROL, 32'h1D);
    wait_start(1'b0);
    rdchk(ADDR_CONTROL, 32'h56);
    wr(ADDR_IRQ_CLEAR, 32'h3);
    rdchk(ADDR_IRQ_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    wr(ADDR_CONTROL, 32'h00);
    rdchk(ADDR_CONTROL, 32'h42);
  endtask
  task automatic t_channels;
    int ch;
    slow <= 1'b0;
    for (ch = 0; ch < 4; ch++) begin
      wr(ADDR_CONTROL, 32'(8 + ch));
      wait_done();
      chk(32'(conv_channel), 32'(ch));
      rdchk(ADDR_RESULT_HI, res_hi(2'(ch)));
      rdchk(ADDR_CONTROL, {24'h0, ~2'(ch), 4'h4, 2'(ch)});
      wr(ADDR_CONTROL, 32'h0);
    end
  endtask
  task automatic t_pin;
    wr(ADDR_IRQ_ENABLE, 32'h0);
    wr(ADDR_IRQ_CLEAR, 32'h3);
    wr(ADDR_CONTROL, 32'h20);
    external_start_pin <= 1'b1;
    wait_start(1'b1);
    external_start_pin <= 1'b0;
    wait_done();
    chk(32'(irq), 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    rdchk(ADDR_IRQ_STATUS, 32'h1);
    chk(32'(irq), 32'h1);
    wr(ADDR_CONTROL, 32'h0);
    external_start_pin <= 1'b1;
    wait_start(1'b0);
    external_start_pin <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sw_conv();
    t_channels();
    t_pin();
    print_verdict();
  end
endmodule // tb_top
